// File: common/tamr_consts.svh
`ifndef TAMR_CONSTS_SVH
`define TAMR_CONSTS_SVH

// ----------------------------------------
// Bus geometry
// ----------------------------------------
`define TAMR_ADR_W 8
`define TAMR_IDX_W 6
`define TAMR_REG_W 16
`define TAMR_RES_W 10

// ----------------------------------------
// Register indexes (byte address = 4 * index)
// ----------------------------------------
`define TAMR_IDX_PANEL 6'h09
`define TAMR_IDX_CONV 6'h0A
`define TAMR_IDX_RESULT 6'h0B
`define TAMR_IDX_IDENT 6'h0C
`define TAMR_IDX_MODE 6'h0D
`define TAMR_IDX_RSVD 6'h0E
`define TAMR_IDX_FILL 6'h0F

// ----------------------------------------
// Touch-panel drive fields
// ----------------------------------------
`define TAMR_GND_LSB 4
`define TAMR_GND_MSB 7
`define TAMR_OP_LSB 8
`define TAMR_OP_MSB 9
`define TAMR_BIAS 11
`define TAMR_PX_LOW 12
`define TAMR_MX_LOW 13
`define TAMR_PANEL_WMASK 16'h0BF0

// ----------------------------------------
// Converter control fields
// ----------------------------------------
`define TAMR_SYNC 0
`define TAMR_REFOUT 1
`define TAMR_SEL_LSB 2
`define TAMR_SEL_MSB 4
`define TAMR_EXTREF 5
`define TAMR_START 7
`define TAMR_POWER 15
`define TAMR_CONV_WMASK 16'h80BF

// ----------------------------------------
// Result and identification fields
// ----------------------------------------
`define TAMR_RES_LSB 5
`define TAMR_RES_MSB 14
`define TAMR_DONE 15
`define TAMR_REV_LSB 0
`define TAMR_REV_MSB 5
`define TAMR_PART_LSB 6
`define TAMR_PART_MSB 11
`define TAMR_MAKER_LSB 12
`define TAMR_MAKER_MSB 15

// ----------------------------------------
// Test and format fields
// ----------------------------------------
`define TAMR_AUDIO_ANALOG_TEST_ON 0
`define TAMR_LINE_TEST 1
`define TAMR_PROD_LSB 2
`define TAMR_PROD_MSB 5
`define TAMR_DYN 12
`define TAMR_OFFC 13
`define TAMR_ABE 14
`define TAMR_TBE 15
`define TAMR_MODE_WMASK 16'hF03F
`define TAMR_TEST_MASK 16'h003F

// ----------------------------------------
// Fixed values
// ----------------------------------------
`define TAMR_ZERO16 16'h0000
`define TAMR_FILL_VALUE 16'hFFFF
`define TAMR_ZERO32 32'h0000_0000

`endif

// File: common/tamr_pkg.sv
`include "tamr_consts.svh"

package tamr_pkg;

    typedef struct packed {
        logic bias_on;
        logic [1:0] operation_select;
        logic plus_y_ground;
        logic minus_y_ground;
        logic plus_x_ground;
        logic minus_x_ground;
    } tamr_panel_t;

    typedef struct packed {
        logic converter_power_on;
        logic external_reference_on;
        logic [2:0] input_select;
        logic reference_out_connect;
        logic converter_sync_on;
    } tamr_conv_t;

    typedef struct packed {
        logic line_big_endian;
        logic audio_big_endian;
        logic audio_offset_cancel_on;
        logic dynamic_valid_flag_on;
        logic [3:0] production_test_select;
        logic line_analog_test_on;
        logic audio_analog_test_on;
    } tamr_mode_t;

    typedef enum logic [2:0] {
        TAMR_OP_INTERRUPT = 3'h1,
        TAMR_OP_PRESSURE = 3'h2,
        TAMR_OP_POSITION = 3'h4
    } tamr_panel_op_t;

    typedef enum logic [2:0] {
        TAMR_SEQ_IDLE = 3'h1,
        TAMR_SEQ_BUSY = 3'h2,
        TAMR_SEQ_DONE = 3'h4
    } tamr_seq_state_t;

endpackage

// File: hdl/tamr_conv_seq.sv
`timescale 1ns/100ps
`include "tamr_consts.svh"

module tamr_conv_seq (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic power_i,
    input wire logic conv_end_i,
    input wire logic [`TAMR_RES_W-1:0] conv_result_i,
    output logic conv_start_o,
    output logic busy_o,
    output logic done_o,
    output logic [`TAMR_RES_W-1:0] result_o
);

    tamr_pkg::tamr_seq_state_t state_reg;
    logic [`TAMR_RES_W-1:0] result_reg;
    logic start_reg;

    // ----------------------------------------
    // Sequence state
    // ----------------------------------------
    // busy falls back to idle on power-down; done holds
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= tamr_pkg::TAMR_SEQ_IDLE;
        end else if (ce_i) begin
            case (state_reg)
                tamr_pkg::TAMR_SEQ_IDLE,
                tamr_pkg::TAMR_SEQ_DONE: begin
                    if (start_i && power_i) begin
                        state_reg <= tamr_pkg::TAMR_SEQ_BUSY;
                    end
                end
                tamr_pkg::TAMR_SEQ_BUSY: begin
                    if (!power_i) begin
                        state_reg <= tamr_pkg::TAMR_SEQ_IDLE;
                    end else if (conv_end_i) begin
                        state_reg <= tamr_pkg::TAMR_SEQ_DONE;
                    end
                end
                default: begin
                    state_reg <= tamr_pkg::TAMR_SEQ_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Launch pulse and result capture
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_reg <= 1'b0;
        end else if (ce_i) begin
            start_reg <= start_i && power_i &&
                         (state_reg != tamr_pkg::TAMR_SEQ_BUSY);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result_reg <= {`TAMR_RES_W{1'b0}};
        end else if (ce_i && power_i && conv_end_i &&
                     state_reg == tamr_pkg::TAMR_SEQ_BUSY) begin
            result_reg <= conv_result_i;
        end
    end

    assign conv_start_o = start_reg;
    assign busy_o = (state_reg == tamr_pkg::TAMR_SEQ_BUSY);
    assign done_o = (state_reg == tamr_pkg::TAMR_SEQ_DONE);
    assign result_o = result_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    result_load_a: assert property ($rose(done_o) |->
        result_o == $past(conv_result_i))
        else $error("Result not taken at conversion end");

    done_clear_a: assert property (start_reg |->
        busy_o && !done_o)
        else $error("Done flag set during conversion");

endmodule // tamr_conv_seq

// File: hdl/tamr_regs.sv
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
`include "tamr_consts.svh"

module tamr_regs #(
    // Arbitrary identification values
    parameter logic [5:0] REVISION_CODE = 6'h2A,
    parameter logic [5:0] PART_CODE = 6'h15,
    parameter logic [3:0] MAKER_CODE = 4'hA
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [`TAMR_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic plus_x_electrode_i,
    input wire logic minus_x_electrode_i,
    input wire logic test_enable_i,
    input wire logic conv_end_i,
    input wire logic [`TAMR_RES_W-1:0] conv_result_i,
    output logic conv_start_o,
    output logic conv_busy_o,
    output logic conv_aux_sel_o,
    output logic reference_drive_o,
    output tamr_pkg::tamr_panel_t panel_o,
    output tamr_pkg::tamr_panel_op_t panel_op_o,
    output tamr_pkg::tamr_conv_t conv_ctrl_o,
    output tamr_pkg::tamr_mode_t mode_o
);

    logic ack_reg;
    logic [31:0] dat_reg;
    logic [`TAMR_REG_W-1:0] panel_reg;
    logic [`TAMR_REG_W-1:0] conv_reg;
    logic [`TAMR_REG_W-1:0] mode_reg;
    logic [`TAMR_REG_W-1:0] rd_next;
    logic [`TAMR_REG_W-1:0] mode_mask;
    logic [`TAMR_IDX_W-1:0] idx;
    logic req;
    logic wr;
    logic start_pulse;
    logic conv_done;
    logic [`TAMR_RES_W-1:0] conv_result;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [`TAMR_REG_W-1:0] merge(
        input logic [`TAMR_REG_W-1:0] old_val,
        input logic [`TAMR_REG_W-1:0] new_val,
        input logic [1:0] sel,
        input logic [`TAMR_REG_W-1:0] mask
    );
        logic [`TAMR_REG_W-1:0] lanes;
        lanes = {{8{sel[1]}}, {8{sel[0]}}} & mask;
        return (old_val & ~lanes) | (new_val & lanes);
    endfunction

    function automatic logic wr_hit(
        input logic [`TAMR_IDX_W-1:0] want
    );
        return wr && (idx == want);
    endfunction

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    assign idx = wb_adr_i[`TAMR_ADR_W-1:2];
    assign req = wb_cyc_i && wb_stb_i && !ack_reg;
    assign wr = req && wb_we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else if (ce_i) begin
            ack_reg <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_reg <= `TAMR_ZERO32;
        end else if (ce_i && req) begin
            dat_reg <= {`TAMR_ZERO16, rd_next};
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        rd_next = `TAMR_ZERO16;
        case (idx)
            `TAMR_IDX_PANEL: begin
                rd_next = panel_reg & `TAMR_PANEL_WMASK;
                rd_next[`TAMR_PX_LOW] = !plus_x_electrode_i;
                rd_next[`TAMR_MX_LOW] = !minus_x_electrode_i;
            end
            `TAMR_IDX_CONV: begin
                rd_next = conv_reg;
            end
            `TAMR_IDX_RESULT: begin
                rd_next[`TAMR_RES_MSB:`TAMR_RES_LSB] = conv_result;
                rd_next[`TAMR_DONE] = conv_done;
            end
            `TAMR_IDX_IDENT: begin
                rd_next[`TAMR_REV_MSB:`TAMR_REV_LSB] = REVISION_CODE;
                rd_next[`TAMR_PART_MSB:`TAMR_PART_LSB] = PART_CODE;
                rd_next[`TAMR_MAKER_MSB:`TAMR_MAKER_LSB] = MAKER_CODE;
            end
            `TAMR_IDX_MODE: begin
                rd_next = mode_reg;
            end
            `TAMR_IDX_FILL: begin
                rd_next = `TAMR_FILL_VALUE;
            end
            default: begin
                rd_next = `TAMR_ZERO16;
            end
        endcase
    end

    // ----------------------------------------
    // Touch-panel drive register
    // ----------------------------------------
    // ground bits, reset zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            panel_reg <= `TAMR_ZERO16;
        end else if (ce_i && wr_hit(`TAMR_IDX_PANEL)) begin
            panel_reg <= merge(panel_reg, wb_dat_i[15:0], wb_sel_i[1:0],
                               `TAMR_PANEL_WMASK);
        end
    end

    assign panel_o = '{
        bias_on: panel_reg[`TAMR_BIAS],
        operation_select: panel_reg[`TAMR_OP_MSB:`TAMR_OP_LSB],
        plus_y_ground: panel_reg[`TAMR_GND_MSB],
        minus_y_ground: panel_reg[`TAMR_GND_LSB + 2],
        plus_x_ground: panel_reg[`TAMR_GND_LSB + 1],
        minus_x_ground: panel_reg[`TAMR_GND_LSB]
    };

    always_comb begin
        if (panel_reg[`TAMR_OP_MSB]) begin
            panel_op_o = tamr_pkg::TAMR_OP_POSITION;
        end else if (panel_reg[`TAMR_OP_LSB]) begin
            panel_op_o = tamr_pkg::TAMR_OP_PRESSURE;
        end else begin
            panel_op_o = tamr_pkg::TAMR_OP_INTERRUPT;
        end
    end

    // ----------------------------------------
    // Converter control register
    // ----------------------------------------
    // sync mode bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_reg <= `TAMR_ZERO16;
        end else if (ce_i && wr_hit(`TAMR_IDX_CONV)) begin
            conv_reg <= merge(conv_reg, wb_dat_i[15:0], wb_sel_i[1:0],
                              `TAMR_CONV_WMASK);
        end
    end

    // launch only on a zero-to-one write
    assign start_pulse = wr_hit(`TAMR_IDX_CONV) && wb_sel_i[0] &&
                         wb_dat_i[`TAMR_START] && !conv_reg[`TAMR_START];

    assign conv_ctrl_o = '{
        converter_power_on: conv_reg[`TAMR_POWER],
        external_reference_on: conv_reg[`TAMR_EXTREF],
        input_select: conv_reg[`TAMR_SEL_MSB:`TAMR_SEL_LSB],
        reference_out_connect: conv_reg[`TAMR_REFOUT],
        converter_sync_on: conv_reg[`TAMR_SYNC]
    };

    // upper selector bit picks auxiliary inputs
    assign conv_aux_sel_o = conv_reg[`TAMR_SEL_MSB];

    // never drive the pin against an external reference
    assign reference_drive_o = conv_reg[`TAMR_REFOUT] &&
                               !conv_reg[`TAMR_EXTREF];

    tamr_conv_seq u_seq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .start_i(start_pulse),
        .power_i(conv_reg[`TAMR_POWER]),
        .conv_end_i(conv_end_i),
        .conv_result_i(conv_result_i),
        .conv_start_o(conv_start_o),
        .busy_o(conv_busy_o),
        .done_o(conv_done),
        .result_o(conv_result)
    );

    // ----------------------------------------
    // Test and format register
    // ----------------------------------------
    // test bits locked without the enable pin
    assign mode_mask = test_enable_i ? `TAMR_MODE_WMASK :
                       (`TAMR_MODE_WMASK & ~`TAMR_TEST_MASK);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg <= `TAMR_ZERO16;
        end else if (ce_i && wr_hit(`TAMR_IDX_MODE)) begin
            mode_reg <= merge(mode_reg, wb_dat_i[15:0], wb_sel_i[1:0],
                              mode_mask);
        end
    end

    assign mode_o = '{
        line_big_endian: mode_reg[`TAMR_TBE],
        audio_big_endian: mode_reg[`TAMR_ABE],
        audio_offset_cancel_on: mode_reg[`TAMR_OFFC],
        dynamic_valid_flag_on: mode_reg[`TAMR_DYN],
        production_test_select: mode_reg[`TAMR_PROD_MSB:`TAMR_PROD_LSB],
        line_analog_test_on: mode_reg[`TAMR_LINE_TEST],
        audio_analog_test_on: mode_reg[`TAMR_AUDIO_ANALOG_TEST_ON]
    };

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    ground_write_a: assert property (
        ce_i && wr && idx == `TAMR_IDX_PANEL && wb_sel_i[0] |=>
        {panel_o.plus_y_ground, panel_o.minus_y_ground,
         panel_o.plus_x_ground, panel_o.minus_x_ground} ==
        $past(wb_dat_i[`TAMR_GND_MSB:`TAMR_GND_LSB]))
        else $error("Ground bits differ from written value");

    op_decode_a: assert property (
        panel_o.operation_select[1] |->
        panel_op_o == tamr_pkg::TAMR_OP_POSITION)
        else $error("Upper mode bit not decoded as position");

    pen_level_a: assert property (
        $rose(wb_ack_o) && $past(idx) == `TAMR_IDX_PANEL |->
        wb_dat_o[`TAMR_MX_LOW:`TAMR_PX_LOW] ==
        ~$past({minus_x_electrode_i, plus_x_electrode_i}))
        else $error("Pen level bits not inverted electrode levels");

    start_edge_a: assert property (
        $rose(conv_start_o) |-> $past(start_pulse) && $past(ce_i))
        else $error("Conversion launched without a rising start bit");

    power_gate_a: assert property (
        conv_start_o |-> conv_ctrl_o.converter_power_on ||
        $past(!ce_i))
        else $error("Conversion launched while powered down");

    busy_flag_a: assert property (
        ce_i && start_pulse && conv_ctrl_o.converter_power_on |=>
        conv_busy_o && !conv_done)
        else $error("Done flag not cleared at launch");

    ident_read_a: assert property (
        $rose(wb_ack_o) && $past(idx) == `TAMR_IDX_IDENT |->
        wb_dat_o[`TAMR_REG_W-1:0] ==
        {MAKER_CODE, PART_CODE, REVISION_CODE})
        else $error("Identification read wrong");

    test_lock_a: assert property (
        ce_i && wr && idx == `TAMR_IDX_MODE && !test_enable_i |=>
        $stable(mode_reg[`TAMR_PROD_MSB:`TAMR_AUDIO_ANALOG_TEST_ON]))
        else $error("Test bits changed without test enable");

    filler_read_a: assert property (
        $rose(wb_ack_o) && $past(idx) == `TAMR_IDX_FILL |->
        wb_dat_o == {`TAMR_ZERO16, `TAMR_FILL_VALUE})
        else $error("Filler register not all ones");

    ref_clash_a: assert property (
        conv_ctrl_o.external_reference_on |-> !reference_drive_o)
        else $error("Internal reference drives external reference pin");

    ack_once_a: assert property (
        wb_ack_o && ce_i |=> !wb_ack_o)
        else $error("Acknowledge held longer than one cycle");

    conv_run_c: cover property (
        conv_start_o ##[1:20] conv_done);
    test_write_c: cover property (
        ce_i && wr && idx == `TAMR_IDX_MODE && test_enable_i);
    pen_down_c: cover property (
        $rose(wb_ack_o) && $past(idx) == `TAMR_IDX_PANEL &&
        wb_dat_o[`TAMR_PX_LOW]);

endmodule // tamr_regs

// File: bench/tamr_adc_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// Converter stand-in
// ----------------------------------------
module tamr_adc_model #(
    parameter int DELAY = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [9:0] value_i,
    output logic end_o,
    output logic [9:0] result_o
);
    int cnt;

    // Result valid only with the end pulse
    assign result_o = end_o ? value_i : ~value_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 0;
            end_o <= 1'b0;
        end else begin
            end_o <= (cnt == 1);
            if (start_i) begin
                cnt <= DELAY;
            end else if (cnt != 0) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule // tamr_adc_model

// File: bench/touch_adc_mode_registers_tb.sv
`timescale 1ns/100ps

module touch_adc_mode_registers_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h3;
    logic [3:0] lanes = 4'h3;
    logic ce = 1'b1;
    tamr_pkg::tamr_panel_t panel;
    tamr_pkg::tamr_conv_t cctl;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] rdat;
    logic ack, cend, cstart, busy, aux, rdrv;
    logic px = 1'b1;
    logic mx = 1'b1;
    logic ten = 1'b0;
    logic [9:0] cres;
    logic [9:0] cval = 10'h2A5;
    logic [15:0] q;
    tamr_pkg::tamr_panel_op_t op;
    tamr_pkg::tamr_mode_t mode;
    int n_errors = 0;
    int comparisons = 0;
    int starts = 0;

    always #5 clk_i = ~clk_i;

    tamr_regs i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .plus_x_electrode_i(px), .minus_x_electrode_i(mx),
        .test_enable_i(ten), .conv_end_i(cend), .conv_result_i(cres),
        .conv_start_o(cstart), .conv_busy_o(busy), .conv_aux_sel_o(aux),
        .reference_drive_o(rdrv), .panel_o(panel), .panel_op_o(op),
        .conv_ctrl_o(cctl), .mode_o(mode));

    tamr_adc_model i_model (.clk_i(clk_i), .rst_i(rst_i), .start_i(cstart),
        .value_i(cval), .end_o(cend), .result_o(cres));

    always @(posedge clk_i) begin
        if (cstart === 1'b1) starts++;
    end

    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Classic single cycle, held until ack
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [15:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= lanes;
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat[15:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        chk({16'h0000, q}, {16'h0000, e});
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy === 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    initial begin
        repeat (5000) @(posedge clk_i);
        n_errors++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h24, 16'h0000);
        rd(8'h28, 16'h0000);
        rd(8'h2C, 16'h0000);
        rd(8'h30, 16'hA56A);
        rd(8'h34, 16'h0000);
        rd(8'h3C, 16'hFFFF);
        rd(8'h00, 16'h0000);
        $display("test reset values done");
        wr(8'h24, 16'hFFFF);
        rd(8'h24, 16'h0BF0);
        chk({25'h0, panel}, 32'h0000_007F);
        px <= 1'b0;
        rd(8'h24, 16'h1BF0);
        px <= 1'b1;
        mx <= 1'b0;
        rd(8'h24, 16'h2BF0);
        lanes <= 4'h1;
        wr(8'h24, 16'h0000);
        lanes <= 4'h3;
        rd(8'h24, 16'h2B00);
        chk({25'h0, panel}, 32'h0000_0070);
        for (int i = 0; i < 4; i++) begin
            wr(8'h24, 16'(i << 8));
            chk({29'h0, op}, {29'h0, (i == 0 ? tamr_pkg::TAMR_OP_INTERRUPT :
                i == 1 ? tamr_pkg::TAMR_OP_PRESSURE :
                tamr_pkg::TAMR_OP_POSITION)});
        end
        $display("test panel done");
        wr(8'h34, 16'hF03F);
        rd(8'h34, 16'hF000);
        // Test pin high while writing test bits
        ten <= 1'b1;
        wr(8'h34, 16'hF03F);
        rd(8'h34, 16'hF03F);
        chk({22'h0, mode}, 32'h0000_03FF);
        // Clock enable low holds off the bus and the registers
        ce <= 1'b0;
        fork
            begin
                repeat (4) @(posedge clk_i);
                chk({31'h0, ack}, 32'h0000_0000);
                chk({22'h0, mode}, 32'h0000_03FF);
                ce <= 1'b1;
            end
        join_none
        wr(8'h34, 16'h0000);
        rd(8'h34, 16'h0000);
        // Probe of the reserved slot and read-only places
        wr(8'h38, 16'hFFFF);
        rd(8'h38, 16'h0000);
        wr(8'h3C, 16'h0000);
        rd(8'h3C, 16'hFFFF);
        wr(8'h30, 16'h0000);
        rd(8'h30, 16'hA56A);
        wr(8'h2C, 16'hFFFF);
        rd(8'h2C, 16'h0000);
        $display("test mode and read-only done");
        for (int i = 0; i < 8; i++) begin
            wr(8'h28, 16'(i << 2));
            rd(8'h28, 16'(i << 2));
            chk({31'h0, aux}, 32'(i >> 2));
        end
        wr(8'h28, 16'h0002);
        chk({31'h0, rdrv}, 32'h0000_0001);
        wr(8'h28, 16'h0022);
        chk({31'h0, rdrv}, 32'h0000_0000);
        wr(8'h28, 16'h0001);
        rd(8'h28, 16'h0001);
        chk({25'h0, cctl}, 32'h0000_0001);
        $display("test converter control done");
        wr(8'h28, 16'h0000);
        wr(8'h28, 16'h0080);
        // Clear then set the start bit for each launch
        wr(8'h28, 16'h0000);
        wr(8'h28, 16'h8000);
        wr(8'h28, 16'h8080);
        chk({31'h0, busy}, 32'h0000_0001);
        chk({25'h0, cctl}, 32'h0000_0040);
        rd(8'h2C, 16'h0000);
        wait_idle();
        rd(8'h2C, 16'hD4A0);
        wr(8'h28, 16'h8080);
        cval <= 10'h3FF;
        wr(8'h28, 16'h8000);
        wr(8'h28, 16'h8080);
        wait_idle();
        rd(8'h2C, 16'hFFE0);
        chk(starts, 32'h0000_0002);
        $display("test conversion done");
        final_report();
    end
endmodule // touch_adc_mode_registers_tb
